/* hdl/baud_defs.vh */
// Purpose: Constants for the serial bit-rate generator
// Assumes: 32-bit APB, byte addresses
// Notes:   Offsets, field positions, reset values, divisor tables
`ifndef BAUD_DEFS_VH
`define BAUD_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_BAUD_RATE_SELECT 12'h000
`define OFS_FINE_PRESCALER 12'h004
`define OFS_RATE_CONTROL 12'h008
`define OFS_RATE_STATUS 12'h00C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_BREAK_LENGTH_ENABLE 6
`define POS_PRESCALE_SEL_HI 5
`define POS_PRESCALE_SEL_LO 4
`define POS_DIVISOR_SEL 0
`define POS_FINE_DIVISOR 5
`define POS_INSERTION 0
`define POS_MODULE_ENABLE 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BAUD_RATE_SELECT 8'h00
`define RST_FINE_PRESCALER 8'h00
`define RST_MODULE_ENABLE 1'b0

// ----------------------------------------
// Divisors and counts
// ----------------------------------------
`define FIRST_DIV_00 4'h1
`define FIRST_DIV_01 4'h3
`define FIRST_DIV_10 4'h4
`define FIRST_DIV_11 4'hD
`define FIXED_PRE_DIV 13'h0004
`define SAMPLES_PER_BIT 5'h10
`define INSERTION_FRAME 6'h20
`define BREAK_BITS_SHORT 4'hB
`define BREAK_BITS_LONG 4'hC

`endif

/* hdl/fine_prescaler.v */
// Purpose: Fractional prescaler with clock insertion
// Assumes: Single clock, tick-style output
// Notes:   Bypass passes every enabled clock through
`timescale 1ns/1ps
`include "baud_defs.vh"
module fine_prescaler (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // Configuration
   input wire run,
   input wire [2:0] fine_prescale_divisor,
   input wire [4:0] clock_insertion_count,
   // Output
   output reg presc_tick
);

   reg [3:0] cyc_reg;
   reg [4:0] acc_reg;
   reg stretch_reg;
   wire bypass;
   wire [3:0] fine_divisor_value;
   wire [3:0] cycle_len;
   wire last;
   wire [5:0] acc_sum;

   assign bypass = (fine_prescale_divisor == 3'h0);
   // Divisor is field value plus one (see R4)
   assign fine_divisor_value = {1'b0, fine_prescale_divisor} + 4'h1;
   // Extended output cycle lasts one extra input clock (see R11)
   assign cycle_len = fine_divisor_value + {3'h0, stretch_reg};
   assign last = (cyc_reg >= cycle_len - 4'h1);
   assign acc_sum = {1'b0, acc_reg} + {1'b0, clock_insertion_count};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_reg <= 4'h0;
         acc_reg <= 5'h00;
         stretch_reg <= 1'b0;
         presc_tick <= 1'b0;
      end else if (clk_en) begin
         if (!run) begin
            cyc_reg <= 4'h0;
            acc_reg <= 5'h00;
            stretch_reg <= 1'b0;
            presc_tick <= 1'b0;
         end else if (bypass) begin
            // Insertion ignored, divide by one (see R10) (see R4)
            cyc_reg <= 4'h0;
            acc_reg <= 5'h00;
            stretch_reg <= 1'b0;
            presc_tick <= 1'b1;
         end else if (last) begin
            cyc_reg <= 4'h0;
            presc_tick <= 1'b1;
            // Accumulator carry spreads N extra clocks over 32 cycles (see R6) (see R11)
            acc_reg <= acc_sum[4:0];
            stretch_reg <= acc_sum[5];
         end else begin
            cyc_reg <= cyc_reg + 4'h1;
            presc_tick <= 1'b0;
         end
      end
   end

endmodule

/* hdl/baud_rate_gen.v */
// Purpose: Bit-rate generator shared by serial receiver and transmitter
// Assumes: APB slave, pclk synchronous inputs, one clock domain
// Notes:   Stages are fine prescaler, fixed 4, first stage, power of two, x16
//
// Functional notes
// (R1) Break length 11 or 12 when enabled
// (R2) First stage divides 1, 3, 4, 13
// (R3) Power-of-two divisor from 1 to 128
// (R4) Fine divisor bypass or field plus one
// (R5) Software avoids bypass changes while enabled
// (R6) Insert N clocks per 32 output cycles
// (R7) Rate is bus over 64 times all divisors
// (R8) One rate clocks receiver and transmitter
// (R9) Reset clears all configuration fields
// (R10) Bypass ignores insertion, divides by one
// (R11) Inserted clocks spread across the frame
`timescale 1ns/1ps
`include "baud_defs.vh"
module baud_rate_gen (
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Receiver character length, 1 selects nine-bit characters
   input wire char_length_sel,
   // Rate outputs to receiver and transmitter
   output reg sample_tick,
   output reg bit_tick,
   output reg [3:0] break_length
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [3:0] first_stage_divisor;
      input [1:0] sel;
      begin
         case (sel)
            2'b00: first_stage_divisor = `FIRST_DIV_00;
            2'b01: first_stage_divisor = `FIRST_DIV_01;
            2'b10: first_stage_divisor = `FIRST_DIV_10;
            default: first_stage_divisor = `FIRST_DIV_11;
         endcase
      end
   endfunction

   function [7:0] power_two_divisor;
      input [2:0] sel;
      begin
         power_two_divisor = 8'h01 << sel;
      end
   endfunction

   function valid_addr;
      input [11:0] a;
      begin
         valid_addr = (a == `OFS_BAUD_RATE_SELECT) || (a == `OFS_FINE_PRESCALER) ||
            (a == `OFS_RATE_CONTROL) || (a == `OFS_RATE_STATUS);
      end
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] baud_rate_select_reg;
   reg [7:0] fine_prescaler_control_reg;
   reg module_enable_reg;
   reg [12:0] stage_cnt_reg;
   reg [12:0] stage_cnt_next;
   reg [3:0] sample_cnt_reg;
   reg [3:0] sample_cnt_next;
   reg sample_fire;
   reg bit_fire;

   wire access;
   wire wr_en;
   wire break_length_enable;
   wire rate_prescale_select_hi;
   wire rate_prescale_select_lo;
   wire [2:0] rate_divisor_select;
   wire [2:0] fine_prescale_divisor;
   wire [4:0] clock_insertion_count;
   wire presc_tick;
   wire [12:0] stage_divisor;
   wire [31:0] read_mux;

   assign break_length_enable = baud_rate_select_reg[`POS_BREAK_LENGTH_ENABLE];
   assign rate_prescale_select_hi = baud_rate_select_reg[`POS_PRESCALE_SEL_HI];
   assign rate_prescale_select_lo = baud_rate_select_reg[`POS_PRESCALE_SEL_LO];
   assign rate_divisor_select = baud_rate_select_reg[`POS_DIVISOR_SEL +: 3];
   assign fine_prescale_divisor = fine_prescaler_control_reg[`POS_FINE_DIVISOR +: 3];
   assign clock_insertion_count = fine_prescaler_control_reg[`POS_INSERTION +: 5];

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // Frozen block holds the bus off rather than drop a write
   assign pready = clk_en;
   assign access = psel && penable && clk_en;
   assign wr_en = access && pwrite && valid_addr(paddr);
   assign pslverr = psel && penable && !valid_addr(paddr);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Configuration cleared (see R9)
         baud_rate_select_reg <= `RST_BAUD_RATE_SELECT;
         fine_prescaler_control_reg <= `RST_FINE_PRESCALER;
         module_enable_reg <= `RST_MODULE_ENABLE;
      end else if (wr_en) begin
         case (paddr)
            `OFS_BAUD_RATE_SELECT: begin
               baud_rate_select_reg <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
            end
            `OFS_FINE_PRESCALER: begin
               // Bypass change while running may glitch (see R5)
               fine_prescaler_control_reg <= pwdata[7:0];
            end
            `OFS_RATE_CONTROL: begin
               module_enable_reg <= pwdata[`POS_MODULE_ENABLE];
            end
            default: begin
               module_enable_reg <= module_enable_reg;
            end
         endcase
      end
   end

   assign read_mux =
      (paddr == `OFS_BAUD_RATE_SELECT) ? {24'h000000, baud_rate_select_reg} :
      (paddr == `OFS_FINE_PRESCALER) ? {24'h000000, fine_prescaler_control_reg} :
      (paddr == `OFS_RATE_CONTROL) ? {31'h0, module_enable_reg} :
      (paddr == `OFS_RATE_STATUS) ? {22'h0, break_length, sample_cnt_reg,
                                     (fine_prescale_divisor == 3'h0), module_enable_reg} :
      32'h00000000;

   // Read data registered at setup so it is stable through access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         if (psel && !penable && !pwrite) begin
            prdata <= read_mux;
         end
      end
   end

   // ----------------------------------------
   // Fine prescaler stage
   // ----------------------------------------
   fine_prescaler u_fine (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .run(module_enable_reg),
      .fine_prescale_divisor(fine_prescale_divisor),
      .clock_insertion_count(clock_insertion_count),
      .presc_tick(presc_tick)
   );

   // ----------------------------------------
   // Integer stages
   // ----------------------------------------
   // Fixed 4 times first stage times power of two; x16 below gives 64 (see R7) (see R2) (see R3)
   // Largest product is 6656, so 13 bits hold it without loss
   assign stage_divisor = `FIXED_PRE_DIV * {9'h0, first_stage_divisor({rate_prescale_select_hi,
      rate_prescale_select_lo})} * {5'h00, power_two_divisor(rate_divisor_select)};

   always @* begin
      stage_cnt_next = stage_cnt_reg;
      sample_cnt_next = sample_cnt_reg;
      sample_fire = 1'b0;
      bit_fire = 1'b0;
      if (!module_enable_reg) begin
         stage_cnt_next = 13'h0000;
         sample_cnt_next = 4'h0;
      end else if (presc_tick) begin
         // Compare with >= so a smaller divisor written mid-count recovers
         if (stage_cnt_reg >= stage_divisor - 13'h0001) begin
            stage_cnt_next = 13'h0000;
            sample_fire = 1'b1;
            sample_cnt_next = sample_cnt_reg + 4'h1;
            bit_fire = ({1'b0, sample_cnt_reg} == (`SAMPLES_PER_BIT - 5'h01));
         end else begin
            stage_cnt_next = stage_cnt_reg + 13'h0001;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_cnt_reg <= 13'h0000;
         sample_cnt_reg <= 4'h0;
         sample_tick <= 1'b0;
         bit_tick <= 1'b0;
      end else if (clk_en) begin
         stage_cnt_reg <= stage_cnt_next;
         sample_cnt_reg <= sample_cnt_next;
         // Same ticks drive both directions (see R8)
         sample_tick <= sample_fire;
         bit_tick <= bit_fire;
      end
   end

   // ----------------------------------------
   // Break length selection
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         break_length <= 4'h0;
      end else if (clk_en) begin
         // Zero means normal operation (see R1)
         if (!break_length_enable) begin
            break_length <= 4'h0;
         end else if (char_length_sel) begin
            break_length <= `BREAK_BITS_LONG;
         end else begin
            break_length <= `BREAK_BITS_SHORT;
         end
      end
   end

endmodule

/* dv/baud_rate_gen_assertions.sv */
// Purpose: Port checks for the bit-rate generator
// Assumes: One clock, async active-low reset
// Notes:   Bound to baud_rate_gen below
`timescale 1ns/1ps
module baud_rate_gen_assertions (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Inputs
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire char_length_sel,
   // Outputs
   input wire pready,
   input wire pslverr,
   input wire sample_tick,
   input wire bit_tick,
   input wire [3:0] break_length
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_bit_on_sample: assert property (bit_tick |-> sample_tick)
      else $error("bit tick without sample tick");
   a_sample_gap: assert property (sample_tick |=> !sample_tick [*3])
      else $error("sample ticks too close");
   a_bit_gap: assert property (bit_tick |=> !bit_tick [*8])
      else $error("bit ticks too close");
   a_break_range: assert property (break_length inside {4'h0, 4'hB, 4'hC})
      else $error("break length out of range");
   a_long_break: assert property (break_length == 4'hC |-> $past(char_length_sel))
      else $error("long break without nine-bit characters");
   a_short_break: assert property (break_length == 4'hB |-> !$past(char_length_sel))
      else $error("short break with nine-bit characters");
   a_reset_clear: assert property ($rose(presetn) |-> !sample_tick && break_length == 4'h0)
      else $error("outputs not cleared by reset");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   a_ready_enable: assert property (pready == clk_en)
      else $error("ready does not follow clock enable");
endmodule

bind baud_rate_gen baud_rate_gen_assertions u_baud_rate_gen_assertions (.pclk, .presetn, .clk_en,
   .psel, .penable, .char_length_sel, .pready, .pslverr, .sample_tick, .bit_tick, .break_length);

/* dv/rate_consumer.sv */
// Purpose: Receiver and transmitter stand-in using the rate ticks
// Assumes: Ticks are one-cycle pulses
// Notes:   Reports sample ticks seen per bit
`timescale 1ns/1ps
module rate_consumer (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Rate inputs
   input wire sample_tick,
   input wire bit_tick,
   // Measurement
   output reg [7:0] smp_per_bit
);
   reg [7:0] cnt_reg;
   // Both directions run from this one pair of ticks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 8'h00;
         smp_per_bit <= 8'h00;
      end else if (bit_tick) begin
         smp_per_bit <= cnt_reg + 8'h01;
         cnt_reg <= 8'h00;
      end else if (sample_tick) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule

/* dv/testbench.sv */
// Purpose: Self-checking bench for the bit-rate generator
// Assumes: APB master tasks, 25 MHz clock
// Notes:   Rates measured over 8 sample ticks
`timescale 1ns/1ps
module testbench;
   reg pclk, presetn, clk_en, psel, penable, pwrite, char_length_sel;
   reg [11:0] paddr;
   reg [31:0] pwdata, rdata;
   reg err;
   wire [31:0] prdata;
   wire pready, pslverr, sample_tick, bit_tick;
   wire [3:0] break_length;
   wire [7:0] smp_per_bit;
   integer n_mismatch, samples_checked, p, cyc;
   baud_rate_gen u_baud_rate_gen (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .char_length_sel(char_length_sel),
      .sample_tick(sample_tick), .bit_tick(bit_tick), .break_length(break_length));
   rate_consumer u_rate_consumer (.pclk(pclk), .presetn(presetn), .sample_tick(sample_tick),
      .bit_tick(bit_tick), .smp_per_bit(smp_per_bit));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] wd);
      integer i;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         i = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && i < 50) begin
            i = i + 1;
            @(posedge pclk);
         end
         if (i == 50) begin
            n_mismatch = n_mismatch + 1;
            print_verdict;
         end
         rdata = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Counts clocks until n sample ticks were seen
   task span(input integer n);
      integer k;
      begin
         cyc = 0;
         k = 0;
         while (k < n && cyc < 20000) begin
            @(posedge pclk);
            cyc = cyc + 1;
            if (sample_tick === 1'b1) k = k + 1;
         end
         if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict;
         end
      end
   endtask
   task rate(input [1:0] ps, input [2:0] dv, input [2:0] fd, input [4:0] ins);
      integer e;
      begin
         // Bypass is not glitch free, so reprogram only while stopped
         apb(1'b1, 12'h008, 32'h0);
         apb(1'b1, 12'h000, {26'h0, ps, 1'b0, dv});
         apb(1'b1, 12'h004, {24'h0, fd, ins});
         apb(1'b1, 12'h008, 32'h1);
         span(2);
         span(8);
         e = (fd == 3'h0) ? 32 : 32 * (fd + 1) + ins;
         e = e * ((ps == 2'h0) ? 1 : (ps == 2'h1) ? 3 : (ps == 2'h2) ? 4 : 13) * (1 << dv);
         check("rate", cyc, e);
      end
   endtask
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      {presetn, psel, penable, pwrite, char_length_sel} = 5'h00;
      clk_en = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      check("brs", rdata, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check("fpc", rdata, 32'h0);
      apb(1'b1, 12'h004, 32'h1FF);
      apb(1'b0, 12'h004, 32'h0);
      check("fpc", rdata, 32'hFF);
      apb(1'b0, 12'h010, 32'h0);
      check("slverr", err, 1'b1);
      apb(1'b1, 12'h000, 32'hFF);
      apb(1'b0, 12'h000, 32'h0);
      check("brs", rdata, 32'h77);
      repeat (2) @(posedge pclk);
      check("brk", break_length, 4'hB);
      char_length_sel <= 1'b1;
      repeat (2) @(posedge pclk);
      check("brk", break_length, 4'hC);
      apb(1'b1, 12'h000, 32'h0);
      repeat (2) @(posedge pclk);
      check("brk", break_length, 4'h0);
      clk_en <= 1'b0;
      repeat (3) @(posedge pclk);
      check("ready", pready, 1'b0);
      clk_en <= 1'b1;
      $display("test registers done");
      for (p = 0; p < 4; p = p + 1) rate(p[1:0], 3'h0, 3'h0, 5'h00);
      for (p = 0; p < 8; p = p + 1) rate(2'h0, p[2:0], 3'h1, 5'h00);
      for (p = 0; p < 8; p = p + 1) rate(2'h1, 3'h1, p[2:0], 5'h05);
      rate(2'h0, 3'h0, 3'h7, 5'h1F);
      span(40);
      check("spb", smp_per_bit, 8'h10);
      apb(1'b0, 12'h008, 32'h0);
      check("ctl", rdata, 32'h1);
      apb(1'b0, 12'h00C, 32'h0);
      check("sts", rdata & 32'h3, 32'h1);
      $display("test rates done");
      print_verdict;
   end
endmodule
